// >>> dsc_defs.svh
// Register map, field positions, reset values and serial framing constants.
`ifndef DSC_DEFS_SVH
`define DSC_DEFS_SVH

// ****************************************************************
// Serial addresses
// ****************************************************************
`define DSC_ADDR_CFG     5'h00
`define DSC_ADDR_FTW     5'h0A
`define DSC_ADDR_PHASE   5'h0B
`define DSC_ADDR_AMP     5'h0C
`define DSC_ADDR_OFFS    5'h0D
`define DSC_ADDR_VER     5'h0E
`define DSC_ADDR_GAP_LO  5'h0F
`define DSC_ADDR_GAP_HI  5'h1C
`define DSC_ADDR_RAM     5'h1D
`define DSC_ADDR_TEST    5'h1E

// ****************************************************************
// Interface configuration byte fields
// ****************************************************************
`define DSC_CFG_THREE_WIRE 7
`define DSC_CFG_LSB_FIRST  6
`define DSC_CFG_SOFT_RST   5
`define DSC_CFG_PWR_DOWN   4
`define DSC_CFG_AUTO_PD    3
`define DSC_CFG_XFER       2
`define DSC_CFG_AUTO_XFER  1
`define DSC_CFG_WMASK      8'hFE
`define DSC_CFG_RST        8'h02

// ****************************************************************
// Reset values and writable masks of the other registers
// ****************************************************************
`define DSC_FTW_RST        32'h0000_0000
`define DSC_PHASE_RST      32'h0000_0000
`define DSC_PHASE_WMASK    32'h03FF_FFFF
`define DSC_AMP_RST        24'h01_0080
`define DSC_AMP_WMASK      24'h03_FFFF
`define DSC_OFFS_RST       32'h0000_0000
`define DSC_RAM_RST        32'h0000_0000

// ****************************************************************
// Serial framing
// ****************************************************************
`define DSC_INSTR_READ     7
`define DSC_INSTR_LAST     6'h07

`endif

// >>> dsc_pkg.sv
// Types and shared helper functions of the serial control register bank.
package dsc_pkg;
`include "dsc_defs.svh"

  // Phases of one serial frame.
  typedef enum logic [1:0] {DSC_IDLE, DSC_INSTR, DSC_DATA, DSC_DONE} dsc_state_t;

  // Number of data bytes that a register occupies on the serial link.
  function automatic logic [2:0] dsc_reg_bytes(input logic [4:0] addr);
    unique case (addr)
      `DSC_ADDR_FTW, `DSC_ADDR_PHASE, `DSC_ADDR_OFFS, `DSC_ADDR_RAM: return 3'h4;
      `DSC_ADDR_AMP, `DSC_ADDR_TEST: return 3'h3;
      `DSC_ADDR_VER: return 3'h2;
      default: return 3'h1;
    endcase
  endfunction

  // Unused bit positions above a word of the given byte count.
  function automatic logic [4:0] dsc_gap_bits(input logic [2:0] nbytes);
    logic [5:0] gap;
    gap = 6'h20 - {nbytes, 3'h0};
    return gap[4:0];
  endfunction

  // Shifts one serial bit into a word in the selected bit order.
  function automatic logic [31:0] dsc_shift_in(input logic [31:0] word, input logic bit_in,
                                               input logic lsb_first);
    return lsb_first ? {bit_in, word[31:1]} : {word[30:0], bit_in};
  endfunction
endpackage

// >>> dsc_reg_if.sv
// Register access channel between the serial link engine and the register bank.
`timescale 1ns/100ps
interface dsc_reg_if;
  logic        wr_stb;
  logic [4:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        lsb_first;
  logic        three_wire;

  // Serial engine side.
  modport link (output wr_stb, addr, wdata, input rdata, lsb_first, three_wire);
  // Register bank side.
  modport bank (input wr_stb, addr, wdata, output rdata, lsb_first, three_wire);
endinterface // dsc_reg_if

// >>> dsc_register_bank.sv
// Serially programmed control register bank of a dual DAC with its frame engine.
// Functional notes
// - Config bit 7 selects three-wire data pin.
// - Config bit 6 selects LSB-first bit order.
// - Soft reset forces registers to defaults.
// - Soft reset leaves config byte untouched.
// - Soft reset holds until host clears it.
// - Config byte is eight bits at address zero.
// - Scale factors: I bits 8:0, Q split.
// - No registers between version and RAM.
// - Auto transfer applies each write at once.
// - Transfer bit copies all buffers, then clears.
`timescale 1ns/100ps
`include "dsc_defs.svh"
module dsc_register_bank import dsc_pkg::*; #(
  parameter logic [7:0] VERSION_ID = 8'h5A  // Arbitrary identification value.
) (
  // Clock and reset.
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  // Serial pins.
  input  wire logic        i_sclk,
  input  wire logic        i_cs_n,
  input  wire logic        i_sdio,
  output logic             o_sdio_out,
  output logic             o_sdio_oe,
  output logic             o_sdo,
  // Active operating values.
  output logic [31:0]      o_ftw,
  output logic [15:0]      o_phase_offset,
  output logic [9:0]       o_phase_corr,
  output logic [8:0]       o_i_scale,
  output logic [8:0]       o_q_scale,
  output logic [15:0]      o_i_offset,
  output logic [15:0]      o_q_offset,
  // Mode levels.
  output logic             o_power_down,
  output logic             o_auto_power_down,
  output logic             o_soft_reset
);

  dsc_reg_if bus_if ();

  // ****************************************************************
  // Serial frame engine
  // ****************************************************************
  dsc_spi_link u_link (
    .i_sys_clk  (i_sys_clk),
    .i_rst      (i_rst),
    .i_sclk     (i_sclk),
    .i_cs_n     (i_cs_n),
    .i_sdio     (i_sdio),
    .o_sdio_out (o_sdio_out),
    .o_sdio_oe  (o_sdio_oe),
    .o_sdo      (o_sdo),
    .bus        (bus_if.link)
  );

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [7:0]  cfg, next_cfg;
  logic [31:0] buf_ftw, next_buf_ftw, buf_phase, next_buf_phase;
  logic [23:0] buf_amp, next_buf_amp, act_amp, next_act_amp;
  logic [31:0] buf_offs, next_buf_offs, ram, next_ram;
  logic [31:0] act_ftw, next_act_ftw, act_phase, next_act_phase;
  logic [31:0] act_offs, next_act_offs;
  logic        wr_buf;

  // Writes, transfers and the level-held soft reset.
  always_comb begin
    next_cfg       = cfg;
    next_buf_ftw   = buf_ftw;
    next_buf_phase = buf_phase;
    next_buf_amp   = buf_amp;
    next_buf_offs  = buf_offs;
    next_ram       = ram;
    next_act_ftw   = act_ftw;
    next_act_phase = act_phase;
    next_act_amp   = act_amp;
    next_act_offs  = act_offs;
    next_cfg[`DSC_CFG_XFER] = 1'b0;
    wr_buf = 1'b0;
    if (bus_if.wr_stb) begin
      unique case (bus_if.addr)
        `DSC_ADDR_CFG:   next_cfg       = bus_if.wdata[7:0] & `DSC_CFG_WMASK;
        `DSC_ADDR_FTW:   next_buf_ftw   = bus_if.wdata;
        `DSC_ADDR_PHASE: next_buf_phase = bus_if.wdata & `DSC_PHASE_WMASK;
        `DSC_ADDR_AMP:   next_buf_amp   = bus_if.wdata[23:0] & `DSC_AMP_WMASK;
        `DSC_ADDR_OFFS:  next_buf_offs  = bus_if.wdata;
        `DSC_ADDR_RAM:   next_ram       = bus_if.wdata;
        // version, gap and test writes are ignored
        default:         next_cfg[`DSC_CFG_XFER] = 1'b0;
      endcase
      wr_buf = bus_if.addr inside {`DSC_ADDR_FTW, `DSC_ADDR_PHASE, `DSC_ADDR_AMP,
                                   `DSC_ADDR_OFFS};
    end
    if ((cfg[`DSC_CFG_AUTO_XFER] && wr_buf) || cfg[`DSC_CFG_XFER]) begin
      next_act_ftw   = next_buf_ftw;
      next_act_phase = next_buf_phase;
      next_act_amp   = next_buf_amp;
      next_act_offs  = next_buf_offs;
    end
    // soft reset holds all but config
    if (cfg[`DSC_CFG_SOFT_RST]) begin
      next_buf_ftw   = `DSC_FTW_RST;
      next_buf_phase = `DSC_PHASE_RST;
      next_buf_amp   = `DSC_AMP_RST;
      next_buf_offs  = `DSC_OFFS_RST;
      next_ram       = `DSC_RAM_RST;
      next_act_ftw   = `DSC_FTW_RST;
      next_act_phase = `DSC_PHASE_RST;
      next_act_amp   = `DSC_AMP_RST;
      next_act_offs  = `DSC_OFFS_RST;
    end
  end

  // Register file state.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg       <= `DSC_CFG_RST;
      buf_ftw   <= `DSC_FTW_RST;
      buf_phase <= `DSC_PHASE_RST;
      buf_amp   <= `DSC_AMP_RST;
      buf_offs  <= `DSC_OFFS_RST;
      ram       <= `DSC_RAM_RST;
      act_ftw   <= `DSC_FTW_RST;
      act_phase <= `DSC_PHASE_RST;
      act_amp   <= `DSC_AMP_RST;
      act_offs  <= `DSC_OFFS_RST;
    end else begin
      cfg       <= next_cfg;
      buf_ftw   <= next_buf_ftw;
      buf_phase <= next_buf_phase;
      buf_amp   <= next_buf_amp;
      buf_offs  <= next_buf_offs;
      ram       <= next_ram;
      act_ftw   <= next_act_ftw;
      act_phase <= next_act_phase;
      act_amp   <= next_act_amp;
      act_offs  <= next_act_offs;
    end
  end

  // Read data; unassigned addresses and the test location read as zero.
  always_comb begin
    unique case (bus_if.addr)
      `DSC_ADDR_CFG:   bus_if.rdata = {24'h00_0000, cfg};
      `DSC_ADDR_FTW:   bus_if.rdata = buf_ftw;
      `DSC_ADDR_PHASE: bus_if.rdata = buf_phase;
      `DSC_ADDR_AMP:   bus_if.rdata = {8'h00, buf_amp};
      `DSC_ADDR_OFFS:  bus_if.rdata = buf_offs;
      `DSC_ADDR_VER:   bus_if.rdata = {24'h00_0000, VERSION_ID};
      `DSC_ADDR_RAM:   bus_if.rdata = ram;
      default:         bus_if.rdata = 32'h0000_0000;
    endcase
  end

  // Mode levels to the link and to the core.
  assign bus_if.lsb_first  = cfg[`DSC_CFG_LSB_FIRST];
  assign bus_if.three_wire = cfg[`DSC_CFG_THREE_WIRE];
  assign o_power_down      = cfg[`DSC_CFG_PWR_DOWN];
  assign o_auto_power_down = cfg[`DSC_CFG_AUTO_PD];
  assign o_soft_reset      = cfg[`DSC_CFG_SOFT_RST];
  assign o_ftw             = act_ftw;
  assign o_phase_offset    = act_phase[15:0];
  assign o_phase_corr      = act_phase[25:16];
  assign o_i_scale         = act_amp[8:0];
  assign o_q_scale         = act_amp[17:9];
  assign o_i_offset        = act_offs[15:0];
  assign o_q_offset        = act_offs[31:16];

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  logic wr_cfg;
  assign wr_cfg = bus_if.wr_stb && bus_if.addr == `DSC_ADDR_CFG;

  a_mode_bits_follow: assert property (wr_cfg |=>
    bus_if.three_wire == $past(bus_if.wdata[7]) && bus_if.lsb_first == $past(bus_if.wdata[6]))
    else $error("Pin mode or bit order did not follow the config write");
  a_soft_reset_force: assert property (cfg[`DSC_CFG_SOFT_RST] |=>
    o_ftw == `DSC_FTW_RST && act_amp == `DSC_AMP_RST && buf_offs == `DSC_OFFS_RST)
    else $error("Soft reset did not force defaults");
  a_config_kept: assert property (
    cfg[`DSC_CFG_SOFT_RST] && !cfg[`DSC_CFG_XFER] && !wr_cfg |=> $stable(cfg))
    else $error("Config byte changed during soft reset");
  a_soft_reset_held: assert property (cfg[`DSC_CFG_SOFT_RST] && !wr_cfg
    |=> o_soft_reset)
    else $error("Soft reset cleared itself");
  a_config_write: assert property (wr_cfg |=> cfg == ($past(bus_if.wdata[7:0]) & 8'hFE))
    else $error("Config write at address zero not stored");
  a_q_scale_split: assert property (
    bus_if.wr_stb && bus_if.addr == `DSC_ADDR_AMP && cfg[1] && !cfg[5]
    |=> o_q_scale == {$past(bus_if.wdata[17:16]), $past(bus_if.wdata[15:9])}
        && o_i_scale == $past(bus_if.wdata[8:0]))
    else $error("Scale factor fields misplaced");
  a_gap_empty: assert property (
    bus_if.addr >= `DSC_ADDR_GAP_LO && bus_if.addr <= `DSC_ADDR_GAP_HI |-> bus_if.rdata == 0)
    else $error("Unassigned address returned data");
  a_auto_apply: assert property (
    bus_if.wr_stb && bus_if.addr == `DSC_ADDR_FTW && cfg[1] && !cfg[5]
    |=> o_ftw == $past(bus_if.wdata))
    else $error("Automatic transfer did not apply the write");
  a_xfer_copy: assert property (cfg[`DSC_CFG_XFER] && !cfg[5] |=>
    act_ftw == $past(buf_ftw) && act_offs == $past(buf_offs) && !cfg[`DSC_CFG_XFER])
    else $error("Transfer did not copy buffers or clear itself");
  a_version_ro: assert property (bus_if.addr == `DSC_ADDR_VER
    |-> bus_if.rdata == {24'h00_0000, VERSION_ID})
    else $error("Version read returned wrong value");
  c_soft_reset: cover property (cfg[5] ##1 !cfg[5]);
  c_manual_xfer: cover property (!cfg[1] && cfg[2]);

endmodule // dsc_register_bank

// >>> dsc_register_bank_tb.sv
// Self-checking testbench of the serial control register bank.
`timescale 1ns/100ps
`include "dsc_defs.svh"
`define CHK(act, exp) \
  begin \
    checked++; \
    if ((act) !== (exp)) begin \
      err_count++; \
      $display("[ERR] %0t got %h expected %h", $time, (act), (exp)); \
    end \
  end
module dsc_register_bank_tb import dsc_pkg::*;;
  localparam logic [7:0] VER = 8'hC3;  // Arbitrary identification value.
  logic        i_sys_clk = 1'b0;
  logic        i_rst;
  logic        sclk, cs_n, sdio, sdio_out, sdio_oe, sdo;
  logic [31:0] o_ftw;
  logic [15:0] o_phase_offset, o_i_offset, o_q_offset;
  logic [9:0]  o_phase_corr;
  logic [8:0]  o_i_scale, o_q_scale;
  logic        o_soft_reset, pd, apd;
  int          err_count = 0;
  int          checked = 0;
  int          oe_seen = 0;
  int          seed;
  logic [31:0] v;
  logic [31:0] sh [4];
  logic [4:0]  adr [4] = '{`DSC_ADDR_FTW, `DSC_ADDR_PHASE, `DSC_ADDR_AMP, `DSC_ADDR_OFFS};
  logic [2:0]  nb [4] = '{3'h4, 3'h4, 3'h3, 3'h4};
  logic [31:0] msk [4] = '{32'hFFFF_FFFF, `DSC_PHASE_WMASK, {8'h0, `DSC_AMP_WMASK}, 32'hFFFF_FFFF};
  logic [4:0]  gap [3] = '{5'h0F, 5'h16, 5'h1C};

  // 100 MHz system clock.
  always #5 i_sys_clk = ~i_sys_clk;

  // Counts cycles in which the device drives the shared pin.
  always @(posedge i_sys_clk) if (sdio_oe === 1'b1) oe_seen++;

  dsc_register_bank #(.VERSION_ID(VER)) dut_u (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_sclk(sclk), .i_cs_n(cs_n), .i_sdio(sdio),
    .o_sdio_out(sdio_out), .o_sdio_oe(sdio_oe), .o_sdo(sdo), .o_ftw(o_ftw),
    .o_phase_offset(o_phase_offset), .o_phase_corr(o_phase_corr), .o_i_scale(o_i_scale),
    .o_q_scale(o_q_scale), .o_i_offset(o_i_offset), .o_q_offset(o_q_offset),
    .o_power_down(pd), .o_auto_power_down(apd), .o_soft_reset(o_soft_reset));

  dsc_spi_host host_u (
    .i_sys_clk(i_sys_clk), .i_dev_out(sdio_out), .i_dev_oe(sdio_oe), .i_dev_sdo(sdo),
    .o_sclk(sclk), .o_cs_n(cs_n), .o_sdio(sdio));

  // ****************************************************************
  // Bus and comparison tasks
  // ****************************************************************
  task automatic wr(input logic [4:0] a, input logic [2:0] n, input logic [31:0] d);
    logic [31:0] r;
    host_u.frame(1'b0, a, n, d, r);
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [2:0] n, input logic [31:0] x);
    logic [31:0] r;
    host_u.frame(1'b1, a, n, 32'h0, r);
    `CHK(r, x)
  endtask

  // Compares all active operating values with the expected buffers.
  task automatic chk_act(input logic [31:0] f, input logic [31:0] p,
                         input logic [31:0] a, input logic [31:0] o);
    `CHK(o_ftw, f)
    `CHK({o_phase_corr, o_phase_offset}, p[25:0])
    `CHK({o_q_scale, o_i_scale}, a[17:0])
    `CHK({o_q_offset, o_i_offset}, o)
  endtask

  // Expected register content after a write: only the writable bits survive.
  function automatic logic [31:0] exp_val(input int k, input logic [31:0] val);
    return val & msk[k];
  endfunction

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Watchdog sized well above the 49 frames of the sequence.
  initial begin
    repeat (80000) @(posedge i_sys_clk);
    err_count++;
    finish_test();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    seed = 53370;
    i_rst = 1'b1;
    repeat (2) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    sh = '{32'h0, 32'h0, {8'h0, `DSC_AMP_RST}, 32'h0};
    rd_chk(`DSC_ADDR_CFG, 3'h1, 32'h02);
    rd_chk(`DSC_ADDR_AMP, 3'h3, sh[2]);
    chk_act(sh[0], sh[1], sh[2], sh[3]);
    // Power-down levels follow the config byte.
    wr(`DSC_ADDR_CFG, 3'h1, 32'h1A);
    `CHK({pd, apd}, 2'b11)
    rd_chk(`DSC_ADDR_CFG, 3'h1, 32'h1A);
    // Random writes, first pass all ones, applied at once with auto transfer.
    for (int i = 0; i < 4; i++) begin
      for (int k = 0; k < 4; k++) begin
        v = (i == 0) ? 32'hFFFF_FFFF : $random(seed);
        wr(adr[k], nb[k], v);
        sh[k] = exp_val(k, v);
        chk_act(sh[0], sh[1], sh[2], sh[3]);
      end
      rd_chk(adr[i], nb[i], sh[i]);
    end
    // Read-only version and unassigned addresses ignore writes.
    wr(`DSC_ADDR_VER, 3'h2, 32'hFFFF);
    rd_chk(`DSC_ADDR_VER, 3'h2, {24'h0, VER});
    foreach (gap[g]) begin
      wr(gap[g], 3'h1, 32'hA5);
      rd_chk(gap[g], 3'h1, 32'h0);
    end
    // Manual transfer holds the tuning word until the transfer bit is set.
    wr(`DSC_ADDR_CFG, 3'h1, 32'h00);
    `CHK({pd, apd}, 2'b00)
    v = $random(seed);
    wr(`DSC_ADDR_FTW, 3'h4, v);
    `CHK(o_ftw, sh[0])
    wr(`DSC_ADDR_CFG, 3'h1, 32'h04);
    `CHK(o_ftw, v)
    rd_chk(`DSC_ADDR_CFG, 3'h1, 32'h00);
    // LSB-first order on a register and the RAM word, then a held soft reset.
    wr(`DSC_ADDR_CFG, 3'h1, 32'h42);
    host_u.lsb_first = 1'b1;
    rd_chk(`DSC_ADDR_FTW, 3'h4, v);
    wr(`DSC_ADDR_RAM, 3'h4, v);
    rd_chk(`DSC_ADDR_RAM, 3'h4, v);
    wr(`DSC_ADDR_CFG, 3'h1, 32'h62);
    `CHK(o_soft_reset, 1'b1)
    chk_act(32'h0, 32'h0, {8'h0, `DSC_AMP_RST}, 32'h0);
    rd_chk(`DSC_ADDR_CFG, 3'h1, 32'h62);
    wr(`DSC_ADDR_FTW, 3'h4, v);
    `CHK(o_ftw, 32'h0)
    wr(`DSC_ADDR_CFG, 3'h1, 32'h42);
    `CHK(o_soft_reset, 1'b0)
    rd_chk(`DSC_ADDR_FTW, 3'h4, 32'h0);
    rd_chk(`DSC_ADDR_RAM, 3'h4, 32'h0);
    `CHK(oe_seen, 0)
    // Three-wire mode returns read data on the shared pin.
    wr(`DSC_ADDR_CFG, 3'h1, 32'h82);
    host_u.lsb_first = 1'b0;
    host_u.three_wire = 1'b1;
    v = $random(seed);
    wr(`DSC_ADDR_OFFS, 3'h4, v);
    rd_chk(`DSC_ADDR_OFFS, 3'h4, v);
    `CHK(oe_seen > 0, 1'b1)
    finish_test();
  end
endmodule // dsc_register_bank_tb

// >>> dsc_spi_host.sv
// Serial host controller model that frames register reads and writes.
`timescale 1ns/100ps
module dsc_spi_host (
  // Clock.
  input  wire logic i_sys_clk,
  // Device serial outputs.
  input  wire logic i_dev_out,
  input  wire logic i_dev_oe,
  input  wire logic i_dev_sdo,
  // Serial pins toward the device.
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_sdio
);
  logic drv;
  logic d;
  logic three_wire;
  logic lsb_first;

  // Resolves the shared data wire; a wire nobody drives shows the inverse of the last host bit.
  assign o_sdio = drv ? d : (i_dev_oe ? i_dev_out : ~d);

  // Idle levels: select high, clock low and still between frames.
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    drv = 1'b1;
    d = 1'b0;
    three_wire = 1'b0;
    lsb_first = 1'b0;
  end

  // Sends one frame; each clock phase lasts 8 system cycles, above the 6-cycle minimum.
  task automatic frame(input logic rd, input logic [4:0] addr, input logic [2:0] nb,
                       input logic [31:0] wdat, output logic [31:0] rdat);
    logic [7:0] instr;
    int         nbits;
    int         j;
    instr = {rd, 2'h0, addr};
    nbits = 8 + 8 * nb;
    rdat = 32'h0;
    @(posedge i_sys_clk) o_cs_n <= 1'b0;
    for (int k = 0; k < nbits; k++) begin
      j = (k < 8) ? (lsb_first ? k : 7 - k) : (lsb_first ? k - 8 : nbits - 1 - k);
      @(posedge i_sys_clk);
      d <= (k < 8) ? instr[j] : wdat[j];
      drv <= !(rd && three_wire && k >= 8);
      repeat (7) @(posedge i_sys_clk);
      o_sclk <= 1'b1;
      if (k >= 8) rdat[j] = three_wire ? o_sdio : i_dev_sdo;
      repeat (8) @(posedge i_sys_clk);
      o_sclk <= 1'b0;
    end
    repeat (8) @(posedge i_sys_clk);
    o_cs_n <= 1'b1;
    drv <= 1'b1;
    repeat (6) @(posedge i_sys_clk);
  endtask
endmodule // dsc_spi_host

// >>> dsc_spi_link.sv
// Oversampling serial slave that turns frames into register reads and writes.
`timescale 1ns/100ps
module dsc_spi_link import dsc_pkg::*; (
  // Clock and reset.
  input  wire logic i_sys_clk,
  input  wire logic i_rst,
  // Serial pins.
  input  wire logic i_sclk,
  input  wire logic i_cs_n,
  input  wire logic i_sdio,
  output logic      o_sdio_out,
  output logic      o_sdio_oe,
  output logic      o_sdo,
  // Register channel.
  dsc_reg_if.link   bus
);

  // ****************************************************************
  // Pin synchronisers and agreement filter
  // ****************************************************************
  logic [2:0] sync_a, sync_b, sync_c, lvl;
  logic [2:0] next_lvl;
  logic       sclk_rise, sclk_fall, cs_high, din;

  // A pin level is taken only once the second and third stages agree.
  always_comb begin
    next_lvl  = (~(sync_b ^ sync_c) & sync_b) | ((sync_b ^ sync_c) & lvl);
    sclk_rise = next_lvl[2] & ~lvl[2];
    sclk_fall = ~next_lvl[2] & lvl[2];
    cs_high   = next_lvl[1];
    din       = next_lvl[0];
  end

  // Synchroniser stages; the first stage feeds only the second.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      sync_a <= 3'h2;
      sync_b <= 3'h2;
      sync_c <= 3'h2;
      lvl    <= 3'h2;
    end else begin
      sync_a <= {i_sclk, i_cs_n, i_sdio};
      sync_b <= sync_a;
      sync_c <= sync_b;
      lvl    <= next_lvl;
    end
  end

  // ****************************************************************
  // Frame engine
  // ****************************************************************
  dsc_state_t  state, next_state;
  logic [5:0]  bit_cnt, next_bit_cnt;
  logic [31:0] rx, next_rx, tx, next_tx, wdata, next_wdata, rx_new;
  logic [4:0]  addr, next_addr;
  logic [2:0]  nbytes, next_nbytes;
  logic        rd, next_rd, tx_load, next_tx_load, wr_stb, next_wr_stb;
  logic        sdo, next_sdo, oe, next_oe;
  logic [7:0]  instr;

  // Instruction: bit 7 selects read, bits 4:0 the address; the data length follows the register.
  always_comb begin
    next_state   = state;
    next_bit_cnt = bit_cnt;
    next_rx      = rx;
    next_tx      = tx;
    next_wdata   = wdata;
    next_addr    = addr;
    next_nbytes  = nbytes;
    next_rd      = rd;
    next_tx_load = 1'b0;
    next_wr_stb  = 1'b0;
    next_sdo     = sdo;
    next_oe      = oe;
    rx_new       = dsc_shift_in(rx, din, bus.lsb_first);
    instr        = bus.lsb_first ? rx_new[31:24] : rx_new[7:0];
    if (cs_high) begin
      next_state = DSC_IDLE;
      next_oe    = 1'b0;
    end else begin
      unique case (state)
        DSC_IDLE: begin
          next_state   = DSC_INSTR;
          next_bit_cnt = 6'h00;
          next_rx      = 32'h0000_0000;
        end
        DSC_INSTR: if (sclk_rise) begin
          next_rx      = rx_new;
          next_bit_cnt = bit_cnt + 6'h01;
          if (bit_cnt == `DSC_INSTR_LAST) begin
            next_state   = DSC_DATA;
            next_bit_cnt = 6'h00;
            next_rx      = 32'h0000_0000;
            next_addr    = instr[4:0];
            next_rd      = instr[`DSC_INSTR_READ];
            next_nbytes  = dsc_reg_bytes(instr[4:0]);
            next_tx_load = instr[`DSC_INSTR_READ];
          end
        end
        DSC_DATA: begin
          // Read data is aligned so that its first serial bit sits at the shifting end.
          if (tx_load) begin
            next_tx = bus.lsb_first ? bus.rdata : bus.rdata << dsc_gap_bits(nbytes);
          end
          if (sclk_fall && rd) begin
            next_sdo = bus.lsb_first ? tx[0] : tx[31];
            next_tx  = bus.lsb_first ? {1'b0, tx[31:1]} : {tx[30:0], 1'b0};
            next_oe  = bus.three_wire;
          end
          if (sclk_rise) begin
            next_rx      = rx_new;
            next_bit_cnt = bit_cnt + 6'h01;
            if (bit_cnt == {nbytes, 3'h0} - 6'h01) begin
              next_state  = DSC_DONE;
              next_wr_stb = ~rd;
              next_wdata  = bus.lsb_first ? rx_new >> dsc_gap_bits(nbytes) : rx_new;
            end
          end
        end
        DSC_DONE: next_state = DSC_DONE;
      endcase
    end
  end

  // Frame engine registers.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state   <= DSC_IDLE;
      bit_cnt <= 6'h00;
      rx      <= 32'h0000_0000;
      tx      <= 32'h0000_0000;
      wdata   <= 32'h0000_0000;
      addr    <= 5'h00;
      nbytes  <= 3'h1;
      rd      <= 1'b0;
      tx_load <= 1'b0;
      wr_stb  <= 1'b0;
      sdo     <= 1'b0;
      oe      <= 1'b0;
    end else begin
      state   <= next_state;
      bit_cnt <= next_bit_cnt;
      rx      <= next_rx;
      tx      <= next_tx;
      wdata   <= next_wdata;
      addr    <= next_addr;
      nbytes  <= next_nbytes;
      rd      <= next_rd;
      tx_load <= next_tx_load;
      wr_stb  <= next_wr_stb;
      sdo     <= next_sdo;
      oe      <= next_oe;
    end
  end

  // Channel and pin drive.
  assign bus.wr_stb = wr_stb;
  assign bus.addr   = addr;
  assign bus.wdata  = wdata;
  assign o_sdio_out = sdo;
  assign o_sdio_oe  = oe;
  assign o_sdo      = sdo;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_lsb_out_order: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (state == DSC_DATA && !cs_high && sclk_fall && rd && bus.lsb_first && !tx_load)
    |=> (o_sdo == $past(tx[0])))
    else $error("LSB-first read did not shift out the low bit");
  a_oe_three_wire: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    o_sdio_oe |-> ($past(bus.three_wire) && rd && state == DSC_DATA || state == DSC_DONE))
    else $error("Data pin driven outside a three-wire read");
  c_write_frame: cover property (@(posedge i_sys_clk) disable iff (i_rst) wr_stb);
  c_three_wire_read: cover property (@(posedge i_sys_clk) disable iff (i_rst) o_sdio_oe);

endmodule // dsc_spi_link
